// ---- design/csfr_map.svh ----
// register offsets, field positions and reset values of the status and flag register slice
`ifndef CSFR_MAP_SVH
`define CSFR_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define CSFR_OFS_STATUS_LOW     8'h00
`define CSFR_OFS_STATUS_HIGH    8'h01
`define CSFR_OFS_FLAG_CLEAR_LOW 8'h02
`define CSFR_OFS_ADC6_HIGH      8'h11
`define CSFR_OFS_ADC1_0_LOW     8'h12
`define CSFR_OFS_ADC3_2_LOW     8'h13
`define CSFR_OFS_ADC5_4_LOW     8'h14
`define CSFR_OFS_ADC6_LOW       8'h15
`define CSFR_OFS_CONV_SEL       8'h19
`define CSFR_OFS_THERM_SEL      8'h1a
`define CSFR_OFS_PART_ID        8'h1f

// ****************************************
// reset values and field layout
// ****************************************
`define CSFR_RST_CONV_SEL       8'h4b
`define CSFR_RST_THERM_SEL      8'h11
`define CSFR_THERM_SEL_MASK     8'h33
`define CSFR_RST_PREV_LEVEL     7'h7f
`define CSFR_CURRENT_LIMIT_LSB  0
`define CSFR_CURRENT_LIMIT_MSB  3
`define CSFR_VOLT_SEL_LSB       4
`define CSFR_VOLT_SEL_MSB       7
`define CSFR_FLAG_LSB           1
`define CSFR_FLAG_MSB           7
`define CSFR_ADC_HIGH_LSB       4
`define CSFR_ADC_HIGH_MSB       11
`define CSFR_ADC_LOW_MSB        3

`endif

// ---- design/csfr_pkg.sv ----
// types shared by the status and flag register slice
package csfr_pkg;

  // ****************************************
  // live condition levels, bit order of status_low
  // ****************************************
  typedef struct packed {
    logic converter_overcurrent;
    logic thermistor_low;
    logic thermistor_high;
    logic converter_temp_recovered;
    logic rectifier_temp_recovered;
    logic converter_overtemp;
    logic rectifier_overtemp;
    logic regulator_supply_ok;
  } csfr_sense_s;

  // ****************************************
  // byte port from the i2c byte engine
  // ****************************************
  typedef struct packed {
    logic       ptr_load;
    logic       wr_strobe;
    logic       rd_start;
    logic       rd_ack;
    logic [7:0] data;
  } csfr_bus_s;

  typedef logic [6:0][11:0] csfr_adc_t;

endpackage : csfr_pkg

// ---- design/csfr_sync.sv ----
// two-stage synchroniser for the asynchronous condition levels
`timescale 1ns/100ps
module csfr_sync (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire csfr_pkg::csfr_sense_s async_in,
  output csfr_pkg::csfr_sense_s      sync_out
);

  typedef struct packed {
    csfr_pkg::csfr_sense_s stage1;
    csfr_pkg::csfr_sense_s stage2;
  } csfr_sync_s;

  csfr_sync_s state;
  csfr_sync_s next_state;

  // ****************************************
  // stage1 feeds stage2 only
  // ****************************************
  always_comb begin
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;

endmodule : csfr_sync

// ---- design/csfr_flag_latch.sv ----
// edge-latched sticky status flags with set-over-clear priority
`timescale 1ns/100ps
`include "csfr_map.svh"
module csfr_flag_latch (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [6:0] level,
  input  wire logic [6:0] clear,
  output logic      [6:0] flags
);

  typedef struct packed {
    logic [6:0] prev;
    logic [6:0] flags;
  } csfr_latch_s;

  csfr_latch_s state;
  csfr_latch_s next_state;

  // ****************************************
  // rising edge sets, clear only where no new edge
  // ****************************************
  always_comb begin
    next_state.prev  = level;
    next_state.flags = (state.flags & ~clear) | (level & ~state.prev);
  end

  // flags are left out of reset on purpose: power-up content is whatever it is
  // prev resets high, but level comes through a synchroniser that resets low, so a condition present at release still sets its flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state.prev <= `CSFR_RST_PREV_LEVEL;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;

endmodule : csfr_flag_latch

// ---- design/csfr_regs.sv ----
// status, adc result, converter select, thermistor select and identity registers
`timescale 1ns/100ps
`include "csfr_map.svh"

module csfr_regs #(
  parameter logic [7:0] PART_CODE = 8'h5a  // arbitrary value
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire csfr_pkg::csfr_bus_s   bus,
  input  wire logic                  auto_increment_enable,
  input  wire logic                  clear_on_read_enable,
  input  wire csfr_pkg::csfr_sense_s sense_pins,
  input  wire logic [7:0]            status_high,
  input  wire logic                  adc_done,
  input  wire csfr_pkg::csfr_adc_t   adc_data,
  output logic [7:0]                 rd_data,
  output logic [7:0]                 status_low,
  output logic                       status_high_clear,
  output logic [7:0]                 converter_level_select,
  output logic [7:0]                 thermistor_limit_select
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] rd_data;
    logic [7:0] conv_sel;
    logic [7:0] therm_sel;
    logic       high_clear;
  } csfr_regs_s;

  csfr_regs_s state;
  csfr_regs_s next_state;

  // byte port command after priority; one strobe a cycle is the normal case
  typedef enum logic [2:0] {
    CMD_IDLE  = 3'b000,
    CMD_PTR   = 3'b001,
    CMD_WRITE = 3'b010,
    CMD_FETCH = 3'b011,
    CMD_ACK   = 3'b100
  } csfr_cmd_e;

  csfr_cmd_e             cmd;
  csfr_pkg::csfr_sense_s sense;
  logic [6:0]            levels;
  logic [6:0]            flags;
  logic [6:0]            flag_clear;
  logic [7:0]            fetch_addr;
  logic                  fetch;
  logic [11:0]           adc_mem [0:6];

  // ****************************************
  // condition inputs
  // ****************************************
  csfr_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (sense_pins),
    .sync_out (sense)
  );

  // thresholds and current limit are applied by the comparators outside,
  // steered by the select registers; only their verdicts come in here
  function automatic logic [6:0] event_levels(input csfr_pkg::csfr_sense_s s);
    logic [6:0] value;
    value[6] = s.converter_overcurrent;
    value[5] = s.thermistor_low;
    value[4] = s.thermistor_high;
    value[3] = s.converter_temp_recovered;
    value[2] = s.rectifier_temp_recovered;
    value[1] = s.converter_overtemp;
    value[0] = s.rectifier_overtemp;
    return value;
  endfunction : event_levels

  assign levels = event_levels(sense);

  csfr_flag_latch u_flags (
    .clk   (clk),
    .rst_n (rst_n),
    .level (levels),
    .clear (flag_clear),
    .flags (flags)
  );

  // ****************************************
  // adc result store
  // ****************************************
  // no reset: contents are undefined until the first conversion lands
  always_ff @(posedge clk) begin
    if (adc_done) begin
      for (int i = 0; i < 7; i++) begin
        adc_mem[i] <= adc_data[i];
      end
    end
  end

  // ****************************************
  // byte assembly
  // ****************************************
  // bit 0 is the live supply level, the rest are the sticky flags
  function automatic logic [7:0] status_low_byte(input logic [6:0] latched,
                                                 input logic       supply_ok);
    return {latched, supply_ok};
  endfunction : status_low_byte

  // low nibbles of two channels share one byte, the odd channel on top
  function automatic logic [7:0] pack_nibbles(input logic [11:0] upper,
                                              input logic [11:0] lower);
    return {upper[`CSFR_ADC_LOW_MSB:0], lower[`CSFR_ADC_LOW_MSB:0]};
  endfunction : pack_nibbles

  // ****************************************
  // read decode
  // ****************************************
  function automatic logic [7:0] read_byte(input logic [7:0] addr);
    logic [7:0] value;
    value = 8'h00;
    case (addr)
      `CSFR_OFS_STATUS_LOW: begin
        value = status_low_byte(flags, sense.regulator_supply_ok);
      end
      `CSFR_OFS_STATUS_HIGH: begin
        value = status_high;
      end
      `CSFR_OFS_ADC6_HIGH: begin
        value = adc_mem[6][`CSFR_ADC_HIGH_MSB:`CSFR_ADC_HIGH_LSB];
      end
      `CSFR_OFS_ADC1_0_LOW: begin
        value = pack_nibbles(adc_mem[1], adc_mem[0]);
      end
      `CSFR_OFS_ADC3_2_LOW: begin
        value = pack_nibbles(adc_mem[3], adc_mem[2]);
      end
      `CSFR_OFS_ADC5_4_LOW: begin
        value = pack_nibbles(adc_mem[5], adc_mem[4]);
      end
      `CSFR_OFS_ADC6_LOW: begin
        value = {4'h0, adc_mem[6][`CSFR_ADC_LOW_MSB:0]};
      end
      `CSFR_OFS_CONV_SEL: begin
        value = state.conv_sel;
      end
      `CSFR_OFS_THERM_SEL: begin
        value = state.therm_sel;
      end
      `CSFR_OFS_PART_ID: begin
        value = PART_CODE;
      end
      default: begin
        value = 8'h00;
      end
    endcase
    return value;
  endfunction : read_byte

  // ****************************************
  // byte port decoding
  // ****************************************
  // several strobes at once mean a confused engine; the pointer load wins
  function automatic csfr_cmd_e decode_cmd(input csfr_pkg::csfr_bus_s b);
    csfr_cmd_e value;
    value = CMD_IDLE;
    if (b.ptr_load) begin
      value = CMD_PTR;
    end else if (b.wr_strobe) begin
      value = CMD_WRITE;
    end else if (b.rd_start) begin
      value = CMD_FETCH;
    end else if (b.rd_ack) begin
      value = CMD_ACK;
    end
    return value;
  endfunction : decode_cmd

  function automatic logic [7:0] step_ptr(input logic [7:0] ptr, input logic inc);
    logic [7:0] value;
    value = ptr;
    if (inc) begin
      value = ptr + 8'h01;
    end
    return value;
  endfunction : step_ptr

  // clear-on-read acts on the fetch, so a prefetch counts as a read
  function automatic logic clearing_fetch(input logic [7:0] addr,
                                          input logic [7:0] target,
                                          input logic       enable);
    return enable && (addr == target);
  endfunction : clearing_fetch

  // ****************************************
  // byte port and register updates
  // ****************************************
  assign cmd = decode_cmd(bus);

  always_comb begin
    next_state            = state;
    next_state.high_clear = 1'b0;
    flag_clear            = 7'h00;
    fetch_addr            = state.ptr;
    fetch                 = 1'b0;
    case (cmd)
      CMD_PTR: begin
        next_state.ptr = bus.data;
      end
      CMD_WRITE: begin
        case (state.ptr)
          `CSFR_OFS_CONV_SEL: begin
            next_state.conv_sel = bus.data;
          end
          `CSFR_OFS_THERM_SEL: begin
            // reserved bits are kept at zero whatever is written
            next_state.therm_sel = bus.data & `CSFR_THERM_SEL_MASK;
          end
          `CSFR_OFS_FLAG_CLEAR_LOW: begin
            flag_clear = bus.data[`CSFR_FLAG_MSB:`CSFR_FLAG_LSB];
          end
          default: begin
            // status registers and read-only bytes take no write
            flag_clear = 7'h00;
          end
        endcase
        next_state.ptr = step_ptr(state.ptr, auto_increment_enable);
      end
      CMD_FETCH: begin
        fetch = 1'b1;
      end
      CMD_ACK: begin
        // the acked byte is gone; prefetch into the cache the next one, or the same one again with auto-increment off
        fetch_addr     = step_ptr(state.ptr, auto_increment_enable);
        next_state.ptr = fetch_addr;
        fetch          = 1'b1;
      end
      default: begin
        next_state.ptr = state.ptr;
      end
    endcase
    if (fetch) begin
      next_state.rd_data = read_byte(fetch_addr);
      if (clearing_fetch(fetch_addr, `CSFR_OFS_STATUS_LOW, clear_on_read_enable)) begin
        // clear all, so unknown power-up flags go too; a fresh edge is or-ed in after
        flag_clear = 7'h7f;
      end
      if (clearing_fetch(fetch_addr, `CSFR_OFS_STATUS_HIGH, clear_on_read_enable)) begin
        // with auto-increment on, prefetch on the lower byte ack already counts as reading the upper
        next_state.high_clear = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state.ptr        <= 8'h00;
      state.rd_data    <= 8'h00;
      state.conv_sel   <= `CSFR_RST_CONV_SEL;
      state.therm_sel  <= `CSFR_RST_THERM_SEL;
      state.high_clear <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rd_data                 = state.rd_data;
  assign status_low              = status_low_byte(flags, sense.regulator_supply_ok);
  assign status_high_clear       = state.high_clear;
  assign converter_level_select  = state.conv_sel;
  assign thermistor_limit_select = state.therm_sel;

endmodule : csfr_regs

// ---- sim/csfr_host.sv ----
// host model that drives the byte port of the register slice
`timescale 1ns/100ps
module csfr_host (
  input  wire logic           clk,
  output csfr_pkg::csfr_bus_s bus
);
  // ********************
  // byte port strobes
  // ********************
  initial bus = '0;
  // one strobe a cycle, raised and dropped at falling edges
  task automatic put(input logic [3:0] f, input logic [7:0] d);
    @(negedge clk);
    bus = {f, d};
    @(negedge clk);
    bus = {4'h0, ~d};  // released data never keeps its last value
  endtask : put
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(4'h8, a);
    put(4'h4, d);  // callers keep reserved bits at zero
  endtask : wr
  task automatic rd(input logic [7:0] a);
    put(4'h8, a);
    put(4'h2, 8'h00);
  endtask : rd
endmodule : csfr_host

// ---- sim/csfr_regs_sva.sv ----
// assertion checker for the status and flag register slice
`timescale 1ns/100ps
module csfr_regs_chk #(
  parameter logic [7:0] PART_CODE = 8'h5a  // arbitrary value
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire csfr_pkg::csfr_bus_s   bus,
  input wire logic                  auto_increment_enable,
  input wire logic                  clear_on_read_enable,
  input wire csfr_pkg::csfr_sense_s sense_pins,
  input wire logic [7:0]            status_high,
  input wire logic                  adc_done,
  input wire csfr_pkg::csfr_adc_t   adc_data,
  input wire logic [7:0]            rd_data,
  input wire logic [7:0]            status_low,
  input wire logic                  status_high_clear,
  input wire logic [7:0]            converter_level_select,
  input wire logic [7:0]            thermistor_limit_select
);
  // ********************
  // pointer shadow and pin history
  // ********************
  logic [7:0]          ptr;
  logic [3:0][7:0]     sh;
  csfr_pkg::csfr_adc_t cap;
  logic                armed;
  logic                wr, rs, ra, quiet;
  logic [6:0]          rise;
  always_comb begin
    wr    = bus.wr_strobe & ~bus.ptr_load;
    rs    = bus.rd_start & ~bus.wr_strobe & ~bus.ptr_load;
    ra    = bus.rd_ack & ~bus.rd_start & ~bus.wr_strobe & ~bus.ptr_load;
    quiet = (sense_pins == sh[0]) && (sh[0] == sh[1]) && (sh[1] == sh[2]);
    rise  = sh[2][7:1] & ~sh[3][7:1];
  end
  // flags power up unknown, so flag checks wait for the first clearing read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr   <= 8'h00;
      sh    <= '1;
      armed <= 1'b0;
    end else begin
      sh <= {sh[2:0], sense_pins};
      if (bus.ptr_load) ptr <= bus.data;
      else if ((wr || ra) && auto_increment_enable) ptr <= ptr + 8'h01;
      if (rs && ptr == 8'h00 && clear_on_read_enable) armed <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (adc_done) cap <= adc_data;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  status_wr_ign_a: assert property (
    (wr && ptr <= 8'h01 && armed) |=> (~status_low[7:1] & $past(status_low[7:1])) == 7'h0)
    else $error("status write dropped a flag");
  high_clear_a: assert property (
    (ra && auto_increment_enable && clear_on_read_enable && ptr == 8'h00)
    |=> status_high_clear && rd_data == $past(status_high))
    else $error("upper status not fetched and cleared");
  supply_live_a: assert property (
    ($past(rst_n) && $past(rst_n, 2))
    |-> status_low[0] == $past(sense_pins.regulator_supply_ok, 2))
    else $error("supply bit not a live level");
  flag_set_a: assert property (
    (armed && rise != 7'h0) |-> (status_low[7:1] & rise) == rise)
    else $error("condition edge not latched");
  read_clear_a: assert property (
    (rs && ptr == 8'h00 && clear_on_read_enable && armed && quiet)
    |=> rd_data == $past(status_low) && status_low[7:1] == 7'h0)
    else $error("clearing read wrong");
  flag_clear_a: assert property (
    (wr && ptr == 8'h02 && armed && quiet) |=> (status_low[7:1] & $past(bus.data[7:1])) == 7'h0
    && (~status_low[7:1] & $past(status_low[7:1]) & ~$past(bus.data[7:1])) == 7'h0)
    else $error("flag clear write wrong");
  adc_pack_a: assert property (
    (rs && ptr == 8'h12) |=> rd_data == {cap[1][3:0], cap[0][3:0]})
    else $error("adc nibble packing wrong");
  part_id_a: assert property (
    (rs && ptr == 8'h1f) |=> rd_data == PART_CODE)
    else $error("identity byte wrong");
  ptr_step_a: assert property (
    (ra && auto_increment_enable && ptr == 8'h1e) |=> rd_data == PART_CODE)
    else $error("pointer did not advance");
endmodule : csfr_regs_chk
bind csfr_regs csfr_regs_chk #(.PART_CODE(PART_CODE)) chk_inst (.clk, .rst_n, .bus,
  .auto_increment_enable, .clear_on_read_enable, .sense_pins, .status_high, .adc_done,
  .adc_data, .rd_data, .status_low, .status_high_clear, .converter_level_select,
  .thermistor_limit_select);

// ---- sim/csfr_regs_tb.sv ----
// self-checking testbench of the status and flag register slice
`timescale 1ns/100ps
module csfr_regs_tb;
  // ********************
  // signals and checks
  // ********************
  logic                  clk, rst_n, ai, cor, adc_done, hi_clr;
  csfr_pkg::csfr_bus_s   bus;
  csfr_pkg::csfr_sense_s sense;
  csfr_pkg::csfr_adc_t   adc;
  logic [7:0]            st_hi, rd_data, st_lo, conv_sel, therm_sel;
  int                    n_mismatch, cmp_count, cyc;
  // {write, address, data, expected read}
  logic [31:0]           rows [12] = '{32'h0019004b, 32'h001a0011, 32'h001f005a,
    32'h01193c3c, 32'h011a2222, 32'h011f005a, 32'h0111006a, 32'h00120098,
    32'h001300ba, 32'h001400dc, 32'h0015000e, 32'h00070000};
  csfr_host host_inst (.clk(clk), .bus(bus));
  csfr_regs csfr_regs_inst (.clk(clk), .rst_n(rst_n), .bus(bus), .auto_increment_enable(ai),
    .clear_on_read_enable(cor), .sense_pins(sense), .status_high(st_hi), .adc_done(adc_done),
    .adc_data(adc), .rd_data(rd_data), .status_low(st_lo), .status_high_clear(hi_clr),
    .converter_level_select(conv_sel), .thermistor_limit_select(therm_sel));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // whole run is a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    rst_n = 1'b0;
    ai = 1'b1;
    cor = 1'b1;
    adc_done = 1'b0;
    sense = '0;
    st_hi = 8'ha5;
    for (int i = 0; i < 7; i++) adc[i] = {4'(i), 4'ha, 4'(i + 8)};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    host_inst.rd(8'h00);
    host_inst.put(4'h1, 8'h00);
    chk(rd_data, 8'ha5);
    chk({7'h0, hi_clr}, 8'h01);
    chk(st_lo, 8'h00);
    host_inst.rd(8'h1e);
    host_inst.put(4'h1, 8'h00);
    chk(rd_data, 8'h5a);
    ai = 1'b0;
    host_inst.rd(8'h1e);
    host_inst.put(4'h1, 8'h00);
    chk(rd_data, 8'h00);
    ai = 1'b1;
    adc_done = 1'b1;
    @(negedge clk);
    adc_done = 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (rows[i][24]) host_inst.wr(rows[i][23:16], rows[i][15:8]);
      host_inst.rd(rows[i][23:16]);
      chk(rd_data, rows[i][7:0]);
    end
    for (int b = 1; b < 8; b++) begin
      sense = 8'h01 << b;
      repeat (4) @(negedge clk);
      sense = '0;
      repeat (4) @(negedge clk);
      chk(st_lo, 8'h01 << b);
      host_inst.wr(8'h02, 8'hfe ^ (8'h01 << b));
      chk(st_lo, 8'h01 << b);
      host_inst.wr(8'h02, 8'h01 << b);
      chk(st_lo, 8'h00);
    end
    sense = 8'h01;
    repeat (3) @(negedge clk);
    chk(st_lo, 8'h01);
    sense = 8'h02;
    repeat (3) @(negedge clk);
    chk(st_lo, 8'h02);
    host_inst.wr(8'h00, 8'hff);
    chk(st_lo, 8'h02);
    cor = 1'b0;
    host_inst.rd(8'h00);
    chk(st_lo, 8'h02);
    cor = 1'b1;
    host_inst.rd(8'h00);
    chk(rd_data, 8'h02);
    chk(st_lo, 8'h00);
    sense = 8'h04;
    repeat (4) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    chk(st_lo, 8'h04);
    chk(conv_sel, 8'h4b);
    chk(therm_sel, 8'h11);
    close_out();
  end
endmodule : csfr_regs_tb
